// ### src/irq_enable_power_status.v
/*
 Interrupt enable, converter power status and protection routing registers,
 reached over the serial register port.
 Assumes all inputs, including the serial clock, are synchronous to clk_sys and
 that the serial clock runs well below a quarter of clk_sys.
*/
`timescale 1ns/1ps
`default_nettype none
`include "irq_power_defs.vh"
module irq_enable_power_status (
   input wire clk_sys,
   input wire rstn,
   input wire sclk,
   input wire csb_n,
   input wire sdi,
   output reg sdo,
   output reg sdo_oe,
   input wire [7:0] events_bank0,
   input wire [7:0] events_bank1,
   input wire i_conv_down_flag,
   input wire q_conv_down_flag,
   input wire i_conv_up_flag,
   input wire q_conv_up_flag,
   input wire transmit_gate_pin,
   input wire power_detect_protect,
   input wire transmit_protect,
   input wire state_machine_protect,
   input wire serial_protect,
   output reg irq_n,
   output reg transmit_gate,
   output reg protect_out
);
   reg [7:0] irq_enable_bank0;
   reg [7:0] irq_enable_bank1;
   reg [7:0] protect_and_transmit_control;
   reg [7:0] latched0;
   reg [7:0] latched1;
   reg sclk_q;
   reg [4:0] bit_cnt;
   reg [15:0] shift_in;
   reg [14:0] addr;
   reg rd_mode;
   reg [7:0] shift_out;
   wire sclk_rise = sclk & ~sclk_q;
   wire sclk_fall = ~sclk & sclk_q;
   wire [15:0] next_shift_in = {shift_in[14:0], sdi};
   wire instr_done = sclk_rise && (bit_cnt == `CNT_INSTR_DONE);
   wire byte_done = sclk_rise && (bit_cnt == `CNT_BYTE_DONE);
   wire wr_strobe = byte_done && !rd_mode;
   wire [14:0] cur_addr = instr_done ? next_shift_in[14:0] : addr;
   wire [14:0] next_addr = cur_addr + 15'h0001;
   wire [7:0] clr0 = (wr_strobe && addr == `ADDR_IRQ_STAT0) ? next_shift_in[7:0] : 8'h00;
   wire [7:0] clr1 = (wr_strobe && addr == `ADDR_IRQ_STAT1) ? next_shift_in[7:0] : 8'h00;
   // Only enabled events latch; the set term wins over a same-cycle clear
   wire [7:0] next_latched0 = ((latched0 & ~clr0) | (events_bank0 & irq_enable_bank0))
      & `MASK_IRQ0;
   wire [7:0] next_latched1 = ((latched1 & ~clr1) | (events_bank1 & irq_enable_bank1))
      & `MASK_IRQ1;

   // Status shows the latch for enabled events and the live level otherwise
   function [7:0] status_view;
      input [7:0] en;
      input [7:0] lat;
      input [7:0] live;
      input [7:0] mask;
      begin
         status_view = ((en & lat) | (~en & live)) & mask;
      end
   endfunction

   function [7:0] read_reg;
      input [14:0] a;
      begin
         case (a)
            `ADDR_PROTECT_CTRL: read_reg = protect_and_transmit_control;
            `ADDR_POWER_STATUS: begin
               read_reg = 8'h00;
               read_reg[`BIT_DOWN_I] = i_conv_down_flag;
               read_reg[`BIT_DOWN_Q] = q_conv_down_flag;
               read_reg[`BIT_UP_I] = i_conv_up_flag;
               read_reg[`BIT_UP_Q] = q_conv_up_flag;
            end
            `ADDR_IRQ_EN0: read_reg = irq_enable_bank0;
            `ADDR_IRQ_EN1: read_reg = irq_enable_bank1;
            `ADDR_IRQ_STAT0: read_reg = status_view(irq_enable_bank0, latched0, events_bank0,
               `MASK_IRQ0);
            `ADDR_IRQ_STAT1: read_reg = status_view(irq_enable_bank1, latched1, events_bank1,
               `MASK_IRQ1);
            default: read_reg = 8'h00;
         endcase
      end
   endfunction

   // Serial frame: instruction bits, then data bytes with address increment
   always @(posedge clk_sys) begin
      if (!rstn) begin
         sclk_q <= 1'b0;
         bit_cnt <= 5'h00;
         shift_in <= 16'h0000;
         addr <= 15'h0000;
         rd_mode <= 1'b0;
         shift_out <= 8'h00;
         sdo <= 1'b0;
         sdo_oe <= 1'b0;
      end else begin
         sclk_q <= sclk;
         if (csb_n) begin
            bit_cnt <= 5'h00;
            rd_mode <= 1'b0;
            sdo_oe <= 1'b0;
         end else begin
            if (sclk_rise) begin
               shift_in <= next_shift_in;
               if (byte_done)
                  bit_cnt <= `CNT_DATA_START;
               else
                  bit_cnt <= bit_cnt + 5'h01;
               if (instr_done) begin
                  rd_mode <= next_shift_in[15];
                  addr <= next_shift_in[14:0];
                  shift_out <= read_reg(next_shift_in[14:0]);
               end
               if (byte_done) begin
                  addr <= next_addr;
                  shift_out <= read_reg(next_addr);
               end
            end
            // Drive data after the falling edge so the master samples it on the rise
            if (sclk_fall && rd_mode) begin
               sdo <= shift_out[7];
               sdo_oe <= 1'b1;
               shift_out <= {shift_out[6:0], 1'b0};
            end
         end
      end
   end

   // Register writes; reserved bits of the enable banks stay zero
   always @(posedge clk_sys) begin
      if (!rstn) begin
         irq_enable_bank0 <= `RST_IRQ_EN0;
         irq_enable_bank1 <= `RST_IRQ_EN1;
         protect_and_transmit_control <= `RST_PROTECT_CTRL;
      end else if (wr_strobe) begin
         if (addr == `ADDR_IRQ_EN0)
            irq_enable_bank0 <= next_shift_in[7:0] & `MASK_IRQ0;
         if (addr == `ADDR_IRQ_EN1)
            irq_enable_bank1 <= next_shift_in[7:0] & `MASK_IRQ1;
         if (addr == `ADDR_PROTECT_CTRL)
            protect_and_transmit_control <= next_shift_in[7:0];
      end
   end

   always @(posedge clk_sys) begin
      if (!rstn) begin
         latched0 <= 8'h00;
         latched1 <= 8'h00;
         irq_n <= 1'b1;
         transmit_gate <= 1'b0;
         protect_out <= 1'b0;
      end else begin
         latched0 <= next_latched0;
         latched1 <= next_latched1;
         irq_n <= ~(|next_latched0 | |next_latched1);
         transmit_gate <= protect_and_transmit_control[`BIT_TX_OVERRIDE] ?
            protect_and_transmit_control[`BIT_TX_LEVEL] : transmit_gate_pin;
         // Force-low beats every source so software can hold the protect line quiet
         protect_out <= ~protect_and_transmit_control[`BIT_PROT_FORCE_LOW] & (
            (protect_and_transmit_control[`BIT_PROT_PDP] & power_detect_protect) |
            (protect_and_transmit_control[`BIT_PROT_TX] & transmit_protect) |
            (protect_and_transmit_control[`BIT_PROT_BSM] & state_machine_protect) |
            (protect_and_transmit_control[`BIT_PROT_SPI] & serial_protect));
      end
   end
endmodule // irq_enable_power_status
`default_nettype wire

// ### src/irq_power_defs.vh
/*
 Constants for the interrupt enable, power status and protection control block.
 Assumes a serial register port: 16-bit instruction, read flag first, then data bytes.
*/
`ifndef IRQ_POWER_DEFS_VH
`define IRQ_POWER_DEFS_VH
`define ADDR_PROTECT_CTRL 15'h0013
`define ADDR_POWER_STATUS 15'h0014
`define ADDR_IRQ_EN0 15'h001F
`define ADDR_IRQ_EN1 15'h0020
`define ADDR_IRQ_STAT0 15'h0023
`define ADDR_IRQ_STAT1 15'h0024
`define RST_PROTECT_CTRL 8'h20
`define RST_IRQ_EN0 8'h00
`define RST_IRQ_EN1 8'h00
`define MASK_IRQ0 8'hDB
`define MASK_IRQ1 8'hF0
`define BIT_PROT_PDP 6
`define BIT_PROT_TX 5
`define BIT_PROT_BSM 4
`define BIT_PROT_SPI 3
`define BIT_PROT_FORCE_LOW 2
`define BIT_TX_OVERRIDE 1
`define BIT_TX_LEVEL 0
`define BIT_DOWN_I 5
`define BIT_DOWN_Q 4
`define BIT_UP_I 1
`define BIT_UP_Q 0
`define CNT_INSTR_DONE 5'h0F
`define CNT_BYTE_DONE 5'h17
`define CNT_DATA_START 5'h10
`endif

// ### sim/irq_props.sv
/* Port checker for irq_enable_power_status.
 Assumes one clock domain, synchronous active-low reset. */
`timescale 1ns/1ps
`default_nettype none
module irq_props (
   input wire clk_sys,
   input wire rstn,
   input wire csb_n,
   input wire sdo_oe,
   input wire irq_n,
   input wire transmit_gate,
   input wire protect_out,
   input wire [7:0] events_bank0,
   input wire [7:0] events_bank1,
   input wire transmit_gate_pin,
   input wire power_detect_protect,
   input wire transmit_protect,
   input wire state_machine_protect,
   input wire serial_protect
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rstn);
   // Control is only known to sit at reset value until a frame starts
   reg used;
   wire ev = |(events_bank0 & 8'hDB) | |(events_bank1 & 8'hF0);
   wire src = power_detect_protect | transmit_protect | state_machine_protect | serial_protect;
   always @(posedge clk_sys) used <= rstn && (used || !csb_n);
   a_reset_irq_idle: assert property (disable iff (1'b0) !rstn |=> irq_n)
      else $error("irq_n low after reset");
   a_reset_outs_low: assert property (disable iff (1'b0) !rstn |=> !protect_out)
      else $error("protect_out high after reset");
   a_oe_frame_end: assert property (csb_n |=> !sdo_oe)
      else $error("sdo_oe high outside frame");
   a_irq_has_cause: assert property ($fell(irq_n) |-> $past(ev) || $past(ev, 2))
      else $error("irq_n fell with no event");
   a_irq_sticky: assert property (!irq_n && csb_n && $past(csb_n) |=> !irq_n)
      else $error("irq_n released without write");
   a_protect_cause: assert property (protect_out |-> $past(src))
      else $error("protect_out with no source");
   a_gate_follow: assert property (!used && $past(rstn) |-> transmit_gate == $past(transmit_gate_pin))
      else $error("transmit_gate not following pin");
   a_tx_prot_follow: assert property (!used && $past(rstn) |-> protect_out == $past(transmit_protect))
      else $error("protect_out not following source");
   c_irq: cover property ($fell(irq_n));
   c_read: cover property ($rose(sdo_oe));
   c_gate: cover property ($rose(transmit_gate) && !transmit_gate_pin);
endmodule // irq_props
bind irq_enable_power_status irq_props u_props (.*);
`default_nettype wire

// ### sim/tb.sv
/* Self-checking bench for irq_enable_power_status.
 Drives every input itself on falling clock edges or up to 3 ns after them. */
`timescale 1ns/1ps
`default_nettype none
module tb;
   reg clk_sys = 0, rstn = 0, sclk = 0, csb_n = 1, sdi = 0, transmit_gate_pin = 0;
   reg [7:0] events_bank0 = 0, events_bank1 = 0, rd, seen, s0, s1;
   reg [3:0] flg = 0, src = 0;
   reg [7:0] oe_seen = 0;
   reg [31:0] rs = 32'hF92EF792;
   wire sdo, sdo_oe, irq_n, transmit_gate, protect_out;
   integer err_count = 0, n_compared = 0, i, k;
   reg [7:0] exp_q[$];
   string what_q[$];
   event got;
   always #12.5 clk_sys = ~clk_sys;
   irq_enable_power_status dut (.i_conv_down_flag(flg[3]), .q_conv_down_flag(flg[2]),
      .i_conv_up_flag(flg[1]), .q_conv_up_flag(flg[0]), .power_detect_protect(src[3]),
      .transmit_protect(src[2]), .state_machine_protect(src[1]), .serial_protect(src[0]), .*);
   function [31:0] xs(input [31:0] v);
      xs = v ^ (v << 13);
      xs = xs ^ (xs >> 17);
      xs = xs ^ (xs << 5);
   endfunction
   task results;
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task check(input string w, input [7:0] s, input [7:0] e);
      n_compared++;
      if (s !== e) begin
         err_count++;
         $display("BAD %s exp %h seen %h", w, e, s);
      end
   endtask
   task note(input string w, input [7:0] s, input [7:0] e);
      what_q.push_back(w);
      exp_q.push_back(e);
      seen = s;
      -> got;
      #1;
   endtask
   always @(got) check(what_q.pop_front(), seen, exp_q.pop_front());
   // Each sclk phase spans two clocks so the block sees every edge
   task xfer(input [23:0] f);
      csb_n = 0;
      for (i = 23; i >= 0; i--) begin
         sdi = f[i];
         sclk = 0;
         repeat (2) @(negedge clk_sys);
         if (i < 8) rd[i] = sdo;
         if (i == 0) oe_seen = {7'h00, sdo_oe};
         sclk = 1;
         repeat (2) @(negedge clk_sys);
      end
      sclk = 0;
      repeat (2) @(negedge clk_sys);
      csb_n = 1;
      repeat (2) @(negedge clk_sys);
   endtask
   task wr(input [14:0] a, input [7:0] d);
      xfer({1'b0, a, d});
   endtask
   task rdchk(input string w, input [14:0] a, input [7:0] e);
      xfer({1'b1, a, 8'h00});
      note(w, rd, e);
      note("sdo_oe", oe_seen, 8'h01);
   endtask
   initial begin
      repeat (12) @(negedge clk_sys);
      rstn = 1;
      rs = xs(rs);
      flg = rs[3:0];
      transmit_gate_pin = rs[4];
      repeat (3) @(negedge clk_sys);
      note("gate", transmit_gate, transmit_gate_pin);
      wr(15'h0014, 8'hFF);
      rdchk("pwr", 15'h0014, {2'b00, flg[3:2], 2'b00, flg[1:0]});
      rdchk("en0_rst", 15'h001F, 8'h00);
      rdchk("ctl_rst", 15'h0013, 8'h20);
      wr(15'h0050, 8'hFF);
      rdchk("unmapped", 15'h0050, 8'h00);
      wr(15'h001F, 8'hFF);
      rdchk("en0", 15'h001F, 8'hDB);
      wr(15'h0020, 8'hFF);
      rdchk("en1", 15'h0020, 8'hF0);
      $display("test registers done");
      rs = xs(rs);
      s0 = rs[7:0] | 8'h01;
      s1 = rs[15:8] | 8'h10;
      events_bank0 = s0;
      events_bank1 = s1;
      repeat (3) @(negedge clk_sys);
      note("irq", irq_n, 8'h00);
      events_bank0 = 0;
      events_bank1 = 0;
      rdchk("lat0", 15'h0023, s0 & 8'hDB);
      rdchk("lat1", 15'h0024, s1 & 8'hF0);
      wr(15'h0023, 8'hFF);
      wr(15'h0024, 8'hFF);
      note("irq_clr", irq_n, 8'h01);
      wr(15'h001F, 8'h00);
      events_bank0 = 8'hDB;
      rdchk("live0", 15'h0023, 8'hDB);
      note("irq_off", irq_n, 8'h01);
      events_bank0 = 0;
      $display("test events done");
      transmit_gate_pin = 0;
      wr(15'h0013, 8'h03);
      note("gate_on", transmit_gate, 8'h01);
      transmit_gate_pin = 1;
      wr(15'h0013, 8'h02);
      note("gate_off", transmit_gate, 8'h00);
      for (k = 0; k < 4; k++) begin
         src = 4'h8 >> k;
         wr(15'h0013, 8'h40 >> k);
         note("prot_on", protect_out, 8'h01);
         wr(15'h0013, (8'h40 >> k) | 8'h04);
         note("prot_low", protect_out, 8'h00);
      end
      $display("test protect done");
      results;
   end
   initial begin
      #500000;
      err_count++;
      results;
   end
endmodule // tb
`default_nettype wire
